// ==== verilog/pom_top.sv ====
// Logic-level PWM output mapping, drive control and power output skew.
// Assumes a classic Wishbone master on clk_in and channel levels
// supplied by the sound datapath on the same clock.
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`include "pom_cfg.svh"
module pom_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic headphone_or_mute_pin_in,
    input pom_pkg::pom_level_t ch1_level_in,
    input pom_pkg::pom_level_t ch2_level_in,
    input pom_pkg::pom_level_t sub_level_in,
    input pom_pkg::pom_level_t xover_hp_level_in,
    input pom_pkg::pom_level_t xover_lp_level_in,
    output logic logic_pwm_out_a_out,
    output logic logic_pwm_oe_n_a_out,
    output logic logic_pwm_out_b_out,
    output logic logic_pwm_oe_n_b_out,
    output logic power_out_1_out,
    output logic power_out_2_out,
    output logic power_out_3_out,
    output logic power_out_4_out
);
    import pom_pkg::*;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg, ctrl_next;
    logic [5:0] skew_reg, skew_next;
    logic [31:0] rdata_next, wmask;
    logic ack_next, access, wr_en;
    logic pin_meta_reg, pin_sync_reg;
    logic [31:0] stat_word;

    // Byte lanes from sel
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            wmask[8*b +: 8] = {8{wb_sel_in[b]}};
    end

    assign access = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr_en = access && wb_we_in;

    // Decode, write and read; unmapped reads return zero, writes dropped
    always_comb
    begin
        ack_next = access;
        ctrl_next = ctrl_reg;
        skew_next = skew_reg;
        rdata_next = wb_dat_out;
        if (wr_en && wb_adr_in == `POM_CTRL_OFS)
            ctrl_next = ((ctrl_reg & ~wmask) | (wb_dat_in & wmask)) & `POM_CTRL_MASK;
        if (wr_en && wb_adr_in == `POM_SKEW_OFS && wb_sel_in[0] && ctrl_reg[`POM_PDN_BIT])
            skew_next = wb_dat_in[5:0];
        if (access && !wb_we_in)
        begin
            unique case (wb_adr_in)
                `POM_CTRL_OFS: rdata_next = ctrl_reg;
                `POM_SKEW_OFS: rdata_next = {26'h0, skew_reg};
                `POM_STAT_OFS: rdata_next = stat_word;
                default: rdata_next = 32'h0;
            endcase
        end
    end

    // Registers; pin passes two flops before any use
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_reg <= `POM_CTRL_RST;
            skew_reg <= `POM_SKEW_RST;
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            skew_reg <= skew_next;
            wb_ack_out <= ack_next;
            wb_dat_out <= rdata_next;
            pin_meta_reg <= headphone_or_mute_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Control fields and pin function
    // ------------------------------------------------------------
    logic drive_en, pin_func, pin_active, hp_act, mute_act, pdn, xover_en, am_shift;
    logic vol_mute, bass_on;
    pom_map_t map_sel;
    pom_layout_t layout;
    pom_rate_t rate;
    pom_skew_t skew;
    pom_level_t levels, mid, duty1, duty2, dutys;

    assign drive_en = ctrl_reg[`POM_DRV_EN_BIT];
    assign map_sel = pom_map_t'(ctrl_reg[`POM_MAP_LSB +: 2]);
    assign pin_func = ctrl_reg[`POM_PIN_FUNC_BIT];
    assign am_shift = ctrl_reg[`POM_AM_SHIFT_BIT];
    assign xover_en = ctrl_reg[`POM_XOVER_BIT];
    assign pdn = ctrl_reg[`POM_PDN_BIT];
    assign bass_on = (ctrl_reg[`POM_BASS_LSB +: 3] != 3'h0);
    assign rate = pom_rate_t'(ctrl_reg[`POM_RATE_LSB +: 2]);
    assign vol_mute = (ctrl_reg[`POM_VOL_LSB +: 8] == `POM_VOL_MUTE);
    assign skew = skew_reg[`POM_SKEW_LSB +: 4];
    assign layout = pom_layout_t'(skew_reg[`POM_LAYOUT_LSB +: 2]);
    assign pin_active = (pin_sync_reg == ctrl_reg[`POM_PIN_POL_BIT]);
    assign hp_act = pin_func && pin_active;
    assign mute_act = !pin_func && pin_active;

    // Levels per period; shift mode sets 56 levels at rate 18, 72 at the other rates
    always_comb
    begin
        levels = `POM_LVL_NOM;
        if (am_shift)
        begin
            unique case (rate)
                POM_CLK_18: levels = `POM_LVL_SH18;
                POM_CLK_24: levels = `POM_LVL_SH24;
                POM_CLK_27: levels = `POM_LVL_SH27;
                default: levels = `POM_LVL_SH27;
            endcase
        end
    end

    // Channel sources; headphone bypasses crossover and bass split
    always_comb
    begin
        mid = levels >> 1;
        duty1 = (xover_en && !hp_act) ? xover_hp_level_in : ch1_level_in;
        duty2 = (xover_en && !hp_act) ? xover_lp_level_in : ch2_level_in;
        dutys = (!bass_on || hp_act) ? mid : sub_level_in;
        if (mute_act || vol_mute)
        begin
            duty1 = mid;
            duty2 = mid;
            dutys = mid;
        end
    end

    // ------------------------------------------------------------
    // Modulators
    // ------------------------------------------------------------
    logic c1, c2, cs, half;

    pom_modulator u_mod1 (.clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(!pdn),
        .levels_in(levels), .duty_in(duty1), .pwm_out(c1), .half_out(half));
    pom_modulator u_mod2 (.clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(!pdn),
        .levels_in(levels), .duty_in(duty2), .pwm_out(c2), .half_out());
    pom_modulator u_mods (.clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(!pdn),
        .levels_in(levels), .duty_in(dutys), .pwm_out(cs), .half_out());

    // ------------------------------------------------------------
    // Logic-level outputs
    // ------------------------------------------------------------
    logic la_next, lb_next, oe_n_next;

    // Drivers float unless enabled; off or stopped drives zero
    always_comb
    begin
        oe_n_next = !drive_en;
        la_next = 1'b0;
        lb_next = 1'b0;
        if (drive_en && !pdn && map_sel != POM_MAP_OFF)
        begin
            if (hp_act)
            begin
                la_next = c1;
                lb_next = c2;
            end
            else if (pin_func)
            begin
                la_next = half; // Idle headphone path sits at mid-scale
                lb_next = half;
            end
            else
            begin
                unique case (map_sel)
                    POM_MAP_OFF: la_next = 1'b0;
                    POM_MAP_C1C2:
                    begin
                        la_next = c1;
                        lb_next = c2;
                    end
                    POM_MAP_C1SUB:
                    begin
                        la_next = c1;
                        lb_next = cs;
                    end
                    POM_MAP_C2SUB:
                    begin
                        la_next = c2;
                        lb_next = cs;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Power outputs with channel skew
    // ------------------------------------------------------------
    logic [3:0] pre, pout_next;
    logic [2:0] dly_a;
    logic [1:0] dly_b;

    // Bridge layout before skew; headphone mode parks the stage at mid
    always_comb
    begin
        logic a, b, s;
        a = hp_act ? half : c1;
        b = hp_act ? half : c2;
        s = hp_act ? half : cs;
        unique case (layout)
            POM_LAY_FULL: pre = {~b, b, ~a, a};
            POM_LAY_HALF3: pre = {~s, s, b, a};
            default: pre = {~a, ~a, a, a};
        endcase
    end

    // First stage delays outputs 2..4, second stage 3/4 again
    pom_skew_line #(.WIDTH(3)) u_skew_a (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .skew_in(skew), .data_in(pre[3:1]), .data_out(dly_a));
    pom_skew_line #(.WIDTH(2)) u_skew_b (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .skew_in(skew), .data_in(dly_a[2:1]), .data_out(dly_b));

    // Pick delayed taps per layout; stopped stage drives zero
    always_comb
    begin
        unique case (layout)
            POM_LAY_FULL: pout_next = {dly_a[2:1], pre[1:0]};
            POM_LAY_HALF3: pout_next = {dly_b, dly_a[0], pre[0]};
            default: pout_next = pre;
        endcase
        if (pdn)
            pout_next = 4'h0;
    end

    // Output flops
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            logic_pwm_out_a_out <= 1'b0;
            logic_pwm_out_b_out <= 1'b0;
            logic_pwm_oe_n_a_out <= 1'b1;
            logic_pwm_oe_n_b_out <= 1'b1;
            {power_out_4_out, power_out_3_out, power_out_2_out, power_out_1_out} <= 4'h0;
        end
        else
        begin
            logic_pwm_out_a_out <= la_next;
            logic_pwm_out_b_out <= lb_next;
            logic_pwm_oe_n_a_out <= oe_n_next;
            logic_pwm_oe_n_b_out <= oe_n_next;
            {power_out_4_out, power_out_3_out, power_out_2_out, power_out_1_out} <= pout_next;
        end
    end

    // Live state for software
    assign stat_word = {17'h0, logic_pwm_oe_n_b_out, logic_pwm_oe_n_a_out, logic_pwm_out_b_out,
        logic_pwm_out_a_out, levels, bass_on, mute_act, hp_act, pin_active};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence skew_write_s;
        wr_en && wb_adr_in == `POM_SKEW_OFS && wb_sel_in[0];
    endsequence
    sequence drive_steady_s;
        (drive_en && !pdn && !pin_func && !mute_act) [*2];
    endsequence

    floating_off_a: assert property (!drive_en |=> logic_pwm_oe_n_a_out && logic_pwm_oe_n_b_out)
        else $error("driver enabled while drive enable clear");
    map_off_low_a: assert property (drive_en && map_sel == POM_MAP_OFF |=>
        !logic_pwm_oe_n_a_out && !logic_pwm_out_a_out && !logic_pwm_out_b_out)
        else $error("disabled map not driven low");
    pdn_low_a: assert property (pdn && drive_en |=> !logic_pwm_out_a_out && !logic_pwm_out_b_out
        && power_out_1_out == 1'b0)
        else $error("power down did not force zero");
    skew_locked_a: assert property (skew_write_s ##0 !pdn |=> $stable(skew_reg))
        else $error("skew changed while running");
    skew_reset_a: assert property (disable iff (1'b0) !rst_n_in |=> skew_reg == `POM_SKEW_RST)
        else $error("skew not cleared by reset");
    route_c2sub_a: assert property (drive_steady_s ##0 map_sel == POM_MAP_C2SUB
        |=> logic_pwm_out_a_out == $past(c2) && logic_pwm_out_b_out == $past(cs))
        else $error("map 11 routed wrongly");
    sub_muted_a: assert property (!bass_on && !mute_act && !vol_mute |-> dutys == mid)
        else $error("sub not muted without bass split");
    hp_route_a: assert property (hp_act && drive_en && !pdn && map_sel != POM_MAP_OFF
        |=> logic_pwm_out_a_out == $past(c1) && logic_pwm_out_b_out == $past(c2))
        else $error("headphone override ignored");
    xover_src_a: assert property (xover_en && !hp_act && !mute_act && !vol_mute
        |-> duty1 == xover_hp_level_in && duty2 == xover_lp_level_in)
        else $error("crossover outputs not on channels 1 and 2");
    shift_levels_a: assert property (am_shift && rate == POM_CLK_18 |-> levels == `POM_LVL_SH18)
        else $error("shift mode level count wrong");
    half3_skew_a: assert property (layout == POM_LAY_HALF3 && skew == 4'h0 && !pdn
        |=> power_out_2_out == $past(pre[1]) && power_out_3_out == $past(pre[2]))
        else $error("three channel outputs skewed at zero");
endmodule

// ==== verilog/pom_cfg.svh ====
// Offsets, field positions, reset values and level counts for the
// logic-level PWM output map and channel skew block.
// Assumes a 32-bit classic Wishbone slave port and a 125 MHz clk_in.
//
// How it works
// - Map select picks off, 1+2, 1+sub, 2+sub
// - Map off drives zero, or high impedance
// - Drivers active only while drive enable set
// - Sub on output B muted without bass
// - Headphone detect overrides the output map, except map off
// - Crossover on: channel 1 high, 2 low
// - Four-bit skew of 0 to 15 cycles
// - Skew time is setting times clock period
// - Skew setting is zero after reset
// - Full bridge: pair 3/4 lags 1/2
// - Three channel: 2 lags 1, 3/4 lag 2
// - Skew writes ignored unless power down set
// - Shift bit sets fewer levels at rate 18, more at 24 and 27
// - Shift levels 56, 72, 72 per clock
// - Drive enable cleared at reset, outputs floating
// - Power down stops modulators, power outputs and enabled drivers drive zero
// - Headphone active: A channel 1, B channel 2
`ifndef POM_CFG_SVH
`define POM_CFG_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define POM_CTRL_OFS 8'h00
`define POM_SKEW_OFS 8'h04
`define POM_STAT_OFS 8'h08

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define POM_DRV_EN_BIT 0
`define POM_MAP_LSB 1
`define POM_PIN_FUNC_BIT 3
`define POM_PIN_POL_BIT 4
`define POM_AM_SHIFT_BIT 5
`define POM_XOVER_BIT 6
`define POM_PDN_BIT 7
`define POM_BASS_LSB 8
`define POM_RATE_LSB 11
`define POM_VOL_LSB 13
`define POM_CTRL_MASK 32'h001F_FFFF
`define POM_CTRL_RST 32'h0000_0080

// ------------------------------------------------------------
// Skew register fields and reset
// ------------------------------------------------------------
`define POM_SKEW_LSB 0
`define POM_LAYOUT_LSB 4
`define POM_SKEW_RST 6'h00

// ------------------------------------------------------------
// Quantization levels per switching period
// ------------------------------------------------------------
`define POM_LVL_NOM 7'h40
`define POM_LVL_SH18 7'h38
`define POM_LVL_SH24 7'h48
`define POM_LVL_SH27 7'h48
`define POM_VOL_MUTE 8'hFF
`define POM_SKEW_MAX 15

`endif

// ==== verilog/pom_pkg.sv ====
// Types shared by the output map block and its submodules.
// Constants live in pom_cfg.svh.
package pom_pkg;
    typedef logic [6:0] pom_level_t;
    typedef logic [3:0] pom_skew_t;
    typedef enum logic [1:0] {POM_MAP_OFF = 2'b00, POM_MAP_C1C2 = 2'b01,
        POM_MAP_C1SUB = 2'b10, POM_MAP_C2SUB = 2'b11} pom_map_t;
    typedef enum logic [1:0] {POM_LAY_FULL = 2'b00, POM_LAY_HALF3 = 2'b01,
        POM_LAY_PAR = 2'b10} pom_layout_t;
    typedef enum logic [1:0] {POM_CLK_18 = 2'b00, POM_CLK_24 = 2'b01,
        POM_CLK_27 = 2'b10} pom_rate_t;
endpackage

// ==== verilog/pom_modulator.sv ====
// One PWM modulator: a period counter compared against a duty level.
// Assumes levels and duty come from logic on the same clock.
`timescale 1ns/1ns
module pom_modulator (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input pom_pkg::pom_level_t levels_in,
    input pom_pkg::pom_level_t duty_in,
    output logic pwm_out,
    output logic half_out
);
    import pom_pkg::*;

    pom_level_t cnt_reg, cnt_next;
    logic pwm_next, half_next;

    // Period counter; stopped modulator rests at zero output
    always_comb
    begin
        cnt_next = '0;
        pwm_next = 1'b0;
        half_next = 1'b0;
        if (run_in)
        begin
            cnt_next = (cnt_reg >= levels_in - 7'h01) ? 7'h00 : cnt_reg + 7'h01;
            pwm_next = (cnt_reg < duty_in);
            half_next = (cnt_reg < (levels_in >> 1)); // Non-modulated mute level
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            cnt_reg <= '0;
            pwm_out <= 1'b0;
            half_out <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            pwm_out <= pwm_next;
            half_out <= half_next;
        end
    end

    // Counter wraps inside the selected number of levels
    count_range_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run_in && $stable(levels_in) && $past(run_in) |-> cnt_reg < levels_in)
        else $error("modulator count left its period");
endmodule

// ==== verilog/pom_skew_line.sv ====
// Tapped delay line: delays a small vector by 0 to 15 clock cycles.
// Assumes the tap setting only changes while the outputs are idle.
`timescale 1ns/1ns
`include "pom_cfg.svh"
module pom_skew_line #(
    parameter int WIDTH = 2
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input pom_pkg::pom_skew_t skew_in,
    input wire logic [WIDTH-1:0] data_in,
    output logic [WIDTH-1:0] data_out
);
    import pom_pkg::*;

    logic [WIDTH-1:0] hist_reg [`POM_SKEW_MAX];
    logic [WIDTH-1:0] hist_next [`POM_SKEW_MAX];

    // One stage per clock of delay, no prescaler
    generate
        for (genvar i = 0; i < `POM_SKEW_MAX; i++)
        begin : g_tap
            always_comb
            begin
                hist_next[i] = (i == 0) ? data_in : hist_reg[(i == 0) ? 0 : i - 1];
            end
            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in)
                    hist_reg[i] <= '0;
                else
                    hist_reg[i] <= hist_next[i];
            end
        end
    endgenerate

    // Tap zero is a straight path
    always_comb
    begin
        data_out = (skew_in == 4'h0) ? data_in : hist_reg[skew_in - 4'h1];
    end

    one_cycle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        skew_in == 4'h1 && $stable(skew_in) |-> data_out == $past(data_in))
        else $error("skew of one cycle not honoured");
    no_skew_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        skew_in == 4'h0 |-> data_out == data_in)
        else $error("zero skew delayed the data");
endmodule

// ==== sim/pom_amp_model.sv ====
// Far-side model of the amplifier that listens to the two logic-level PWM pins.
// Assumes oe_n high means the block has let go of the pin and nothing pulls it.
`timescale 1ns/1ns
module pom_amp_model (
    input wire logic clk_in,
    input wire logic sig_a_in,
    input wire logic oe_n_a_in,
    input wire logic sig_b_in,
    input wire logic oe_n_b_in,
    output logic wire_a_out,
    output logic wire_b_out
);
    logic flip_reg = 1'b0;

    // No pull resistor, so a released pin wanders every cycle
    always @(posedge clk_in)
    begin
        flip_reg <= ~flip_reg;
    end

    // Level seen at the amplifier input
    assign wire_a_out = oe_n_a_in ? flip_reg : sig_a_in;
    assign wire_b_out = oe_n_b_in ? ~flip_reg : sig_b_in;
endmodule

// ==== sim/tb_pwm_output_map_skew_shift.sv ====
// Self-checking bench for the output map, drive control, skew and rate shift.
// Assumes the 1-cycle Wishbone answer and 64-level nominal period of the block.
`timescale 1ns/1ns
`include "pom_cfg.svh"
module tb_pwm_output_map_skew_shift;
    import pom_pkg::*;
    // Pin idles high: inactive for the active-low mute polarity
    logic clk_in = 1'b0, rst_n_in = 1'b0, wb_cyc = 1'b0, wb_we = 1'b0, pin = 1'b1;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0, wb_rd, wb_dat_out, lfsr = 32'hDF2F;
    logic [31:0] m_ctrl = 32'h0000_0080, m_skew = 32'h0;
    pom_level_t c1 = 7'h0A, c2 = 7'h14, cs = 7'h1E, hp = 7'h0C, lp = 7'h28;
    logic wb_ack, oa, ob, na, nb, wire_a, wire_b;
    logic [3:0] pw;
    int err_total = 0, n_checks = 0, d, ea, eb, s;
    integer ha, hb;

    always #4 clk_in = ~clk_in;

    pom_top i_pom_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_cyc),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hF), .wb_dat_in(wb_dat),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack), .headphone_or_mute_pin_in(pin),
        .ch1_level_in(c1), .ch2_level_in(c2), .sub_level_in(cs), .xover_hp_level_in(hp),
        .xover_lp_level_in(lp), .logic_pwm_out_a_out(oa), .logic_pwm_oe_n_a_out(na),
        .logic_pwm_out_b_out(ob), .logic_pwm_oe_n_b_out(nb), .power_out_1_out(pw[0]),
        .power_out_2_out(pw[1]), .power_out_3_out(pw[2]), .power_out_4_out(pw[3]));
    pom_amp_model i_pom_amp_model (.clk_in(clk_in), .sig_a_in(oa), .oe_n_a_in(na), .sig_b_in(ob),
        .oe_n_b_in(nb), .wire_a_out(wire_a), .wire_b_out(wire_b));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_of_test;
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input integer got, input integer exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    // Classic cycle; the watchdog is the only limit on the wait for ack
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_in);
        wb_cyc <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do @(posedge clk_in); while (wb_ack !== 1'b1);
        wb_rd = wb_dat_out;
        wb_cyc <= 1'b0;
    endtask

    // Writes also update the bench's register model
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, dat);
        if (adr == `POM_CTRL_OFS)
            m_ctrl = dat & `POM_CTRL_MASK;
        if (adr == `POM_SKEW_OFS && m_ctrl[7])
            m_skew = dat & 32'h3F;
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0);
        chk_val(wb_rd, exp);
    endtask

    function automatic logic [31:0] mk(input int vol, rate, bass, pdn, xo, am, hpm, map, de);
        return (vol << 13) | (rate << 11) | (bass << 8) | (pdn << 7) | (xo << 6) | (am << 5)
            | (hpm * 24) | (map << 1) | de;
    endfunction

    function automatic int lv(input int am, input int rate);
        return am ? (rate == 0 ? 56 : 72) : 64;
    endfunction

    // One step of the bench's random source
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // New random channel levels, kept inside the shortest period
    task automatic rnd;
        @(posedge clk_in);
        lfsr = lfsr_step(lfsr);
        c1 <= 7'(lfsr[7:0] % 50 + 1);
        c2 <= 7'(lfsr[15:8] % 50 + 1);
        cs <= 7'(lfsr[23:16] % 50 + 1);
    endtask

    // High time over one full period after the pipeline settles
    task automatic meas(input int n);
        ha = 0;
        hb = 0;
        repeat (160) @(negedge clk_in);
        repeat (n) @(negedge clk_in)
        begin
            ha += wire_a;
            hb += wire_b;
        end
    endtask

    // Cycles from a rise of power output 1 to the next rise of pw[t] (power output t+1), or its fall if inv is set
    task automatic lag(input int t, input logic inv, input int exp);
        int r, k;
        logic p1, pt;
        r = -1;
        d = -1;
        p1 = 1'b1;
        pt = 1'b1;
        for (k = 0; k < 300 && d < 0; k++)
        begin
            @(negedge clk_in);
            if (pw[0] && !p1 && r < 0)
                r = k;
            if ((pw[t] ^ inv) && !pt && r >= 0)
                d = k - r;
            p1 = pw[0];
            pt = pw[t] ^ inv;
        end
        chk_cnt(d, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(`POM_CTRL_OFS, m_ctrl);
        chk_val({na, nb}, 32'h3);
        rd(`POM_SKEW_OFS, 32'h0);
        rd(8'h0C, 32'h0);
        wr(`POM_CTRL_OFS, mk(0, 0, 0, 0, 0, 0, 0, 0, 0));
        wr(`POM_SKEW_OFS, 32'h5);
        rd(`POM_SKEW_OFS, m_skew);
        meas(8);
        chk_val({na, nb}, 32'h3);
        for (int m = 0; m < 4; m++)
            for (int b = 0; b < 2; b++)
            begin
                rnd;
                wr(`POM_CTRL_OFS, mk(0, 0, b, 0, 0, 0, 0, m, 1));
                meas(64);
                ea = (m == 0) ? 0 : (m == 3) ? c2 : c1;
                eb = (m == 0) ? 0 : (m == 1) ? c2 : (b ? cs : 32);
                chk_cnt(ha, ea);
                chk_cnt(hb, eb);
                chk_val({na, nb}, 32'h0);
            end
        wr(`POM_CTRL_OFS, mk(0, 0, 1, 0, 1, 0, 0, 1, 1));
        meas(64);
        chk_cnt(ha, hp);
        chk_cnt(hb, lp);
        @(posedge clk_in);
        pin <= 1'b1;
        wr(`POM_CTRL_OFS, mk(0, 0, 0, 0, 0, 0, 1, 3, 1));
        meas(64);
        chk_cnt(ha, c1);
        chk_cnt(hb, c2);
        @(posedge clk_in);
        pin <= 1'b0;
        meas(64);
        chk_cnt(ha + hb, 64);
        // Pin back to idle so mute mode sees it inactive
        @(posedge clk_in);
        pin <= 1'b1;
        // Shutdown order: mute, release the drivers, then power down with unmuted drivers enabled again
        wr(`POM_CTRL_OFS, mk(255, 0, 1, 0, 0, 0, 0, 1, 1));
        meas(64);
        chk_cnt(ha, 32);
        wr(`POM_CTRL_OFS, mk(255, 0, 1, 0, 0, 0, 0, 1, 0));
        @(negedge clk_in);
        chk_val({na, nb}, 32'h3);
        wr(`POM_CTRL_OFS, mk(0, 0, 1, 1, 0, 0, 0, 1, 1));
        meas(64);
        chk_cnt(ha + hb, 0);
        chk_val({na, nb}, 32'h0);
        for (int r = 0; r < 3; r++)
        begin
            rnd;
            wr(`POM_CTRL_OFS, mk(0, r, 1, 0, 0, 1, 0, 1, 1));
            meas(lv(1, r));
            chk_cnt(ha, c1);
            wb_xfer(1'b0, `POM_STAT_OFS, 32'h0);
            chk_val(wb_rd[10:4], lv(1, r));
        end
        @(posedge clk_in);
        c1 <= 7'h14;
        c2 <= 7'h14;
        cs <= 7'h14;
        for (int l = 0; l < 2; l++)
            for (int k = 0; k < 4; k++)
            begin
                s = (k == 3) ? lfsr % 16 : (k == 2) ? 15 : k;
                wr(`POM_CTRL_OFS, mk(0, 0, 1, 1, 0, 0, 0, 1, 1));
                wr(`POM_SKEW_OFS, (l << 4) | s);
                rd(`POM_SKEW_OFS, m_skew);
                wr(`POM_CTRL_OFS, mk(0, 0, 1, 0, 0, 0, 0, 1, 1));
                repeat (160) @(negedge clk_in);
                if (l == 0)
                begin
                    lag(2, 1'b0, s);
                    lag(3, 1'b1, s);
                    lag(1, 1'b1, 0);
                end
                else
                begin
                    lag(1, 1'b0, s);
                    lag(2, 1'b0, 2 * s);
                    lag(3, 1'b1, 2 * s);
                end
            end
        end_of_test;
    end

    // Watchdog: the whole run needs well under this span
    initial
    begin
        #800000;
        err_total++;
        end_of_test;
    end
endmodule
